// [hdl/tcc_regs.svh]
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

// byte addresses of the six byte-wide registers, one word each
`define TCC_ADDR_CTRL0 32'h0000_0000
`define TCC_ADDR_CTRL1 32'h0000_0004
`define TCC_ADDR_VAL0_HIGH 32'h0000_0008
`define TCC_ADDR_VAL0_LOW 32'h0000_000C
`define TCC_ADDR_VAL1_HIGH 32'h0000_0010
`define TCC_ADDR_VAL1_LOW 32'h0000_0014

// word indices (address bits 4:2) derived from the addresses above
`define TCC_IDX_CTRL_BASE 3'h0
`define TCC_IDX_VAL_BASE 3'h2

// control and status field positions
`define TCC_BIT_FLAG 7
`define TCC_BIT_IRQ_EN 6
`define TCC_BIT_BUFFERED 5
`define TCC_BIT_MODE_A 4
`define TCC_BIT_ELS_HIGH 3
`define TCC_BIT_ELS_LOW 2
`define TCC_BIT_TOGGLE_OVF 1
`define TCC_BIT_MAX_DUTY 0

// reset values
`define TCC_CTRL_RESET 8'h00
`define TCC_OUT_RESET 1'b1

// edge/level codes
`define TCC_ELS_NONE 2'h0
`define TCC_ELS_TOGGLE 2'h1
`define TCC_ELS_LOW 2'h2
`define TCC_ELS_HIGH 2'h3

`endif

// [hdl/tcc_pkg.sv]
package tcc_pkg;

  typedef struct packed {
    logic channel_event_flag;
    logic channel_irq_enable;
    logic buffered_mode_select;
    logic mode_select_a;
    logic edge_level_high_bit;
    logic edge_level_low_bit;
    logic toggle_on_overflow;
    logic max_duty_force;
  } tcc_ctrl_type;

  typedef struct packed {
    logic [15:0] value;
    logic overflow;
    logic counter_stop;
  } tcc_counter_type;

  typedef enum logic [1:0] {
    tcc_mode_off = 2'b00,
    tcc_mode_capture = 2'b01,
    tcc_mode_compare = 2'b10
  } tcc_mode_type;

endpackage

// [hdl/tcc_channels.sv]
// The implementer's own choices: the AHB-Lite slave port and the address map.
`include "tcc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module tcc_channels
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire tcc_pkg::tcc_counter_type counter_link,
  input wire logic [1:0] channel_pin_in,
  output logic [1:0] channel_pin_out,
  output logic [1:0] channel_pin_oe,
  output logic [1:0] channel_irq
);

  localparam int CHANNELS = 2;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: writes land in the data phase, reads take one wait state

  logic dph_wr;
  logic dph_rd;
  logic dph_map;
  logic [2:0] dph_idx;
  logic last_wr_ch1;
  logic [15:0] cmp_buf;
  logic [7:0] ctrl_rd [CHANNELS];
  logic [15:0] val_rd [CHANNELS];
  logic [7:0] rd_byte;
  logic buf_on;

  wire accept = hsel & htrans[1] & hready;
  wire addr_map = (haddr[31:5] == 27'h000_0000) & (haddr[4:2] <= 3'h5)
    & (haddr[1:0] == 2'h0);
  // hsize is not checked: only whole-word single transfers are issued
  wire unused_size = &hsize;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dph_wr <= 1'b0;
      dph_rd <= 1'b0;
      dph_map <= 1'b0;
      dph_idx <= 3'h0;
    end
    else
    begin
      dph_wr <= accept & hwrite;
      dph_rd <= accept & ~hwrite;
      dph_map <= addr_map & ~unused_size | addr_map;
      dph_idx <= haddr[4:2];
    end
  end

  // read data is taken after the data-phase edge, so a write just before
  // is already visible
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= ~(accept & ~hwrite);
      hresp <= 1'b0;
      if (dph_rd)
      begin
        hrdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign rd_byte = !dph_map ? 8'h00 :
    (dph_idx == `TCC_IDX_CTRL_BASE) ? ctrl_rd[0] :
    (dph_idx == 3'(`TCC_IDX_CTRL_BASE + 3'h1)) ? ctrl_rd[1] :
    (dph_idx == `TCC_IDX_VAL_BASE) ? val_rd[0][15:8] :
    (dph_idx == 3'(`TCC_IDX_VAL_BASE + 3'h1)) ? val_rd[0][7:0] :
    (dph_idx == 3'(`TCC_IDX_VAL_BASE + 3'h2)) ? val_rd[1][15:8] :
    val_rd[1][7:0];

  ////////////////////////////////////////////////////////////////////////////
  // buffered compare register shared by both channel value registers

  wire wr_lo0 = dph_wr & dph_map & (dph_idx == 3'(`TCC_IDX_VAL_BASE + 3'h1));
  wire wr_lo1 = dph_wr & dph_map & (dph_idx == 3'(`TCC_IDX_VAL_BASE + 3'h3));

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      last_wr_ch1 <= 1'b0;
    else if (wr_lo1)
      last_wr_ch1 <= 1'b1;
    else if (wr_lo0)
      last_wr_ch1 <= 1'b0;
  end

  // load at overflow
  // a new value never lands mid-period, so no glitch on the pulse width
  always_ff @(posedge sys_clk)
  begin
    if (counter_link.overflow)
      cmp_buf <= last_wr_ch1 ? val_rd[1] : val_rd[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // channels

  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_ch
    localparam logic [2:0] CTRL_IDX = 3'(`TCC_IDX_CTRL_BASE + i);
    localparam logic [2:0] HI_IDX = 3'(`TCC_IDX_VAL_BASE + 2 * i);
    localparam logic [2:0] LO_IDX = 3'(`TCC_IDX_VAL_BASE + 2 * i + 1);

    tcc_pkg::tcc_ctrl_type ctrl;
    tcc_pkg::tcc_mode_type mode;
    logic [15:0] val;
    logic rlock;
    logic wlock;
    logic arm;
    logic out;
    logic oe;
    logic irq;
    logic max_eff;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;

    wire wr_ctrl = dph_wr & dph_map & (dph_idx == CTRL_IDX);
    wire rd_ctrl = dph_rd & dph_map & (dph_idx == CTRL_IDX);
    wire wr_hi = dph_wr & dph_map & (dph_idx == HI_IDX);
    wire wr_lo = dph_wr & dph_map & (dph_idx == LO_IDX);
    wire rd_hi = dph_rd & dph_map & (dph_idx == HI_IDX);
    wire rd_lo = dph_rd & dph_map & (dph_idx == LO_IDX);

    // buffered bit only on channel 0
    wire is_buf = (i == 0) & ctrl.buffered_mode_select;
    // channel 1 taken off while buffered
    wire dis = (i != 0) & buf_on;
    wire [1:0] els = {ctrl.edge_level_high_bit, ctrl.edge_level_low_bit};

    assign mode = (dis | (els == `TCC_ELS_NONE)) ? tcc_pkg::tcc_mode_off :
      (is_buf | ctrl.mode_select_a) ? tcc_pkg::tcc_mode_compare :
      tcc_pkg::tcc_mode_capture;

    wire rise = pin_s2 & ~pin_s3;
    wire fall = ~pin_s2 & pin_s3;
    wire cap_ev = (mode == tcc_pkg::tcc_mode_capture)
      & ~counter_link.counter_stop & ~rlock
      & ((els[0] & rise) | (els[1] & fall));
    wire [15:0] cmp_val = is_buf ? cmp_buf : val;
    wire cmp_ev = (mode == tcc_pkg::tcc_mode_compare) & ~wlock
      & (counter_link.value == cmp_val);
    // overflow action in compare mode only
    wire ovf_act = (mode == tcc_pkg::tcc_mode_compare)
      & ctrl.toggle_on_overflow & counter_link.overflow;
    wire chan_ev = cap_ev | cmp_ev;

    // the second and third stages feed the edge detector
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        pin_s1 <= 1'b0;
        pin_s2 <= 1'b0;
        pin_s3 <= 1'b0;
      end
      else
      begin
        pin_s1 <= channel_pin_in[i];
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
      end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
        ctrl <= tcc_pkg::tcc_ctrl_type'(`TCC_CTRL_RESET);
      else
      begin
        if (wr_ctrl & ~dis)
        begin
          ctrl.channel_irq_enable <= hwdata[`TCC_BIT_IRQ_EN];
          // channel 1 has no buffered bit: it always reads back zero
          ctrl.buffered_mode_select <= (i == 0)
            & hwdata[`TCC_BIT_BUFFERED];
          ctrl.mode_select_a <= hwdata[`TCC_BIT_MODE_A];
          ctrl.edge_level_high_bit <= hwdata[`TCC_BIT_ELS_HIGH];
          ctrl.edge_level_low_bit <= hwdata[`TCC_BIT_ELS_LOW];
          ctrl.toggle_on_overflow <= hwdata[`TCC_BIT_TOGGLE_OVF];
          ctrl.max_duty_force <= hwdata[`TCC_BIT_MAX_DUTY];
        end
        if (chan_ev)
          ctrl.channel_event_flag <= 1'b1;
        // only a zero after the armed read clears
        else if (wr_ctrl & ~dis & arm & ~hwdata[`TCC_BIT_FLAG])
          ctrl.channel_event_flag <= 1'b0;
      end
    end

    // arm on read with flag set; a new event disarms
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
        arm <= 1'b0;
      else if (chan_ev)
        arm <= 1'b0;
      else if (rd_ctrl & ~dis)
        arm <= ctrl.channel_event_flag;
      else if (wr_ctrl)
        arm <= 1'b0;
    end

    // byte latching of the value pair
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        rlock <= 1'b0;
        wlock <= 1'b0;
      end
      else
      begin
        if (rd_hi & (mode == tcc_pkg::tcc_mode_capture))
          rlock <= 1'b1;
        else if (rd_lo)
          rlock <= 1'b0;
        if (wr_hi & (mode != tcc_pkg::tcc_mode_capture))
          wlock <= 1'b1;
        else if (wr_lo)
          wlock <= 1'b0;
      end
    end

    // no reset on the value pair
    // capture beats a bus write in the same cycle: the event is not lost
    always_ff @(posedge sys_clk)
    begin
      if (cap_ev)
        val <= counter_link.value;
      else if (wr_hi)
        val[15:8] <= hwdata[7:0];
      else if (wr_lo)
        val[7:0] <= hwdata[7:0];
    end

    // max duty sampled only at period boundaries
    // sampling it mid-period would shorten or stretch one pulse
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
        max_eff <= 1'b0;
      else if (counter_link.overflow)
        max_eff <= ctrl.max_duty_force & ctrl.toggle_on_overflow;
    end

    // channel output level
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
        out <= `TCC_OUT_RESET;
      else if (mode == tcc_pkg::tcc_mode_off)
        out <= ~ctrl.mode_select_a;
      else if (ovf_act)
        out <= ctrl.max_duty_force | ~out;
      // compare action, held off at full duty
      else if (cmp_ev & ~max_eff)
      begin
        case (els)
          `TCC_ELS_TOGGLE: out <= ~out;
          `TCC_ELS_LOW: out <= 1'b0;
          `TCC_ELS_HIGH: out <= 1'b1;
          default: out <= out;
        endcase
      end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        oe <= 1'b0;
        irq <= 1'b0;
      end
      else
      begin
        oe <= (mode == tcc_pkg::tcc_mode_compare);
        irq <= ctrl.channel_irq_enable & ctrl.channel_event_flag;
      end
    end

    // disabled channel 1 control reads as zero
    assign ctrl_rd[i] = dis ? 8'h00 : ctrl;
    assign val_rd[i] = val;
    assign channel_pin_out[i] = out;
    assign channel_pin_oe[i] = oe;
    assign channel_irq[i] = irq;
  end

  // channel 0 owns the buffered mode; channel 1 only follows it
  assign buf_on = g_ch[0].ctrl.buffered_mode_select;

endmodule // tcc_channels

`default_nettype wire

// [tb/tcc_properties.sv]
`timescale 1ns/100ps
`default_nettype none
`include "tcc_regs.svh"
module tcc_properties
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [1:0] channel_pin_out,
  input wire logic [1:0] channel_pin_oe,
  input wire logic [1:0] channel_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire take = hsel && htrans[1] && hready;
  ////////////////////////////////////////////////////////////
  sequence s_ctl0_wr;
    take && hwrite && haddr == `TCC_ADDR_CTRL0 ##1 hready;
  endsequence
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout && hrdata[31:8] == 24'h00_0000;
  endsequence
  a_okay_resp: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (take && !hwrite |=> s_rd_answer)
    else $error("read answer timing wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_pins_reset: assert property ($rose(reset_n) |->
    channel_pin_out == 2'b11 && !channel_pin_oe && !channel_irq)
    else $error("outputs not at reset level");
  a_irq_masked: assert property (s_ctl0_wr ##0 !hwdata[6]
    |=> ##1 !channel_irq[0])
    else $error("irq with enable low");
  a_idle_level: assert property (s_ctl0_wr ##0 hwdata[3:2] == 2'b00
    |=> ##1 !channel_pin_oe[0] && channel_pin_out[0] == !$past(hwdata[4], 2))
    else $error("idle pin level wrong");
  a_compare_drive: assert property (s_ctl0_wr ##0
    hwdata[5:4] != 2'b00 && hwdata[3:2] != 2'b00 |=> ##1 channel_pin_oe[0])
    else $error("compare pin not driven");
  a_capture_float: assert property (s_ctl0_wr ##0
    hwdata[5:4] == 2'b00 && hwdata[3:2] != 2'b00 |=> ##1 !channel_pin_oe[0])
    else $error("capture pin driven");
endmodule // tcc_properties
bind tcc_channels tcc_properties u_props (.sys_clk, .reset_n, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .channel_pin_out, .channel_pin_oe, .channel_irq);
`default_nettype wire

// [tb/tcc_pin_model.sv]
`timescale 1ns/100ps
`default_nettype none
module tcc_pin_model
(
  input wire logic [1:0] drive_level,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pin_in
);
  // source level held by caller
  // the channel wins the wire while it drives
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive_level);
endmodule // tcc_pin_model
`default_nettype wire

// [tb/test_timer_channel_capture_compare.sv]
`timescale 1ns/100ps
`default_nettype none
`include "tcc_regs.svh"
module test_timer_channel_capture_compare;
  logic sys_clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, lvl, pin_in, pin_out, pin_oe, irq;
  tcc_pkg::tcc_counter_type cnt;
  int fails, total_checks;
  tcc_channels u_dut (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .counter_link(cnt), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
    .channel_pin_oe(pin_oe), .channel_irq(irq));
  tcc_pin_model u_pins (.drive_level(lvl), .pin_out, .pin_oe, .pin_in);
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 50)
    begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("pins", {pin_oe, pin_out, irq}, 32'h0000_000C);
    bus(0, `TCC_ADDR_CTRL0, 0);
    check("ctrl0", r, 32'h0000_0000);
    bus(0, 32'h0000_0018, 0);
    check("unmapped", r, 32'h0000_0000);
  endtask
  task automatic t_capture();
    cnt.value <= 16'h1234;
    bus(1, `TCC_ADDR_CTRL0, 32'h0000_0044);
    cyc(2);
    lvl <= 2'b01;
    cyc(6);
    check("irq", irq, 32'h0000_0001);
    bus(1, `TCC_ADDR_CTRL0, 32'h0000_00C4);
    bus(0, `TCC_ADDR_CTRL0, 0);
    check("flag", r, 32'h0000_00C4);
    bus(0, `TCC_ADDR_VAL0_HIGH, 0);
    check("high", r, 32'h0000_0012);
    bus(0, `TCC_ADDR_VAL0_LOW, 0);
    check("low", r, 32'h0000_0034);
    bus(1, `TCC_ADDR_CTRL0, 32'h0000_0044);
    bus(0, `TCC_ADDR_CTRL0, 0);
    check("cleared", r, 32'h0000_0044);
    cnt.counter_stop <= 1'b1;
    lvl <= 2'b00;
    cyc(6);
    lvl <= 2'b01;
    cyc(6);
    bus(0, `TCC_ADDR_CTRL0, 0);
    check("stopped", r, 32'h0000_0044);
    cnt.counter_stop <= 1'b0;
    bus(1, `TCC_ADDR_CTRL0, 32'h0000_0048);
    lvl <= 2'b00;
    cyc(6);
    bus(0, `TCC_ADDR_CTRL0, 0);
    check("falling", r, 32'h0000_00C8);
  endtask
  task automatic match_pulse(logic ovf);
    cnt.value <= 16'h0010;
    cnt.overflow <= ovf;
    cyc(1);
    cnt.value <= 16'h0000;
    cnt.overflow <= 1'b0;
    cyc(3);
  endtask
  task automatic ovf_pulse();
    cnt.overflow <= 1'b1;
    cyc(1);
    cnt.overflow <= 1'b0;
    cyc(3);
  endtask
  task automatic t_compare();
    // bench counter is held at zero while mode bits change
    cnt.value <= 16'h0000;
    bus(1, `TCC_ADDR_VAL0_HIGH, 0);
    bus(1, `TCC_ADDR_VAL0_LOW, 32'h0000_0010);
    bus(1, `TCC_ADDR_CTRL0, 32'h0000_0010);
    cyc(3);
    check("preset", {pin_oe[0], pin_out[0]}, 32'h0000_0000);
    bus(1, `TCC_ADDR_CTRL0, 32'h0000_001C);
    match_pulse(0);
    check("set", {pin_oe[0], pin_out[0]}, 32'h0000_0003);
    bus(0, `TCC_ADDR_CTRL0, 0);
    check("cmpflag", r, 32'h0000_009C);
    bus(1, `TCC_ADDR_CTRL0, 32'h0000_001A);
    cnt.overflow <= 1'b1;
    cyc(1);
    cnt.overflow <= 1'b0;
    cyc(3);
    check("tov", pin_out[0], 32'h0000_0000);
    // clear action would give low; overflow toggle must win
    match_pulse(1);
    check("ovfwins", pin_out[0], 32'h0000_0001);
    bus(1, `TCC_ADDR_CTRL0, 32'h0000_0018);
    bus(1, `TCC_ADDR_VAL0_HIGH, 0);
    match_pulse(0);
    check("locked", pin_out[0], 32'h0000_0001);
    bus(1, `TCC_ADDR_VAL0_LOW, 32'h0000_0010);
    match_pulse(0);
    check("unlocked", pin_out[0], 32'h0000_0000);
  endtask
  task automatic t_buffered();
    bus(1, `TCC_ADDR_CTRL1, 32'h0000_0040);
    bus(0, `TCC_ADDR_CTRL1, 0);
    check("ctrl1", r, 32'h0000_0040);
    bus(1, `TCC_ADDR_CTRL0, 32'h0000_003C);
    bus(0, `TCC_ADDR_CTRL1, 0);
    check("ch1off", r, 32'h0000_0000);
    check("ch1pin", {pin_oe[1], irq[1]}, 32'h0000_0000);
    bus(1, `TCC_ADDR_VAL0_HIGH, 0);
    bus(1, `TCC_ADDR_VAL0_LOW, 32'h0000_0020);
    match_pulse(0);
    check("bufold", pin_out[0], 32'h0000_0001);
    bus(1, `TCC_ADDR_CTRL0, 32'h0000_0038);
    ovf_pulse();
    match_pulse(0);
    check("bufheld", pin_out[0], 32'h0000_0001);
    cnt.value <= 16'h0020;
    cyc(1);
    cnt.value <= 16'h0000;
    cyc(3);
    check("bufnew", pin_out[0], 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    {reset_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    cnt = '0;
    lvl = 2'b00;
    fails = 0;
    total_checks = 0;
    cyc(12);
    reset_n <= 1'b1;
    cyc(1);
    t_reset();
    t_capture();
    t_compare();
    t_buffered();
    report_and_stop();
  end
endmodule // test_timer_channel_capture_compare
`default_nettype wire
